// ===== rtl/flrsp_fault_limit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - sixteen-bit over-current threshold at 0x46
// - sixteen-bit under-current threshold at 0x4B
// - sixteen-bit over-temperature threshold at 0x4F
// - thresholds by word, action by byte
// - any temperature fault: alert low, flag set
// - mode 00 keeps the output running
// - mode 01 runs on for delay units
// - mode 01 fault persisting then follows retry
// - mode 10 disables at once, then retries
// - retry 000 stays off until cleared
// - retry 001 one attempt, then latched off
// - attempt starts spaced by delay units
// - retry code gives number of attempts
// - unit 80 ms running, 32 ms retrying
// - retry 111 retries until output disabled
module flrsp_fault_limit
    import flrsp_pkg::*;
#(
    parameter int RUN_UNIT = RUN_UNIT_CYC,
    parameter int RETRY_UNIT = RETRY_UNIT_CYC
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // decoded command transfers from the serial bus engine
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_word,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] rsp_rdata,
    output logic rsp_valid,
    output logic rsp_err,
    // measurements from the converter logic
    input wire logic temp_valid,
    input wire logic [15:0] temp_value,
    input wire logic iout_valid,
    input wire logic [15:0] iout_value,
    // host control
    input wire logic op_enable,
    input wire logic fault_clear,
    // status and power stage
    output logic out_enable,
    output logic ot_fault_flag,
    output logic oc_fault_flag,
    output logic uc_fault_flag,
    output logic alert_output_line_n
);

    // whole state of the block
    typedef struct packed {
        flrsp_state_t st;
        logic [TMR_W-1:0] tmr;
        logic [2:0] tries;
        logic [15:0] oc_lim;
        logic [15:0] uc_lim;
        logic [15:0] ot_lim;
        logic [7:0] ot_act;
        logic ot_now;
        logic ot_flag;
        logic oc_flag;
        logic uc_flag;
        logic out_en;
        logic [15:0] rdata;
        logic rvalid;
        logic rerr;
    } flrsp_regs_t;

    localparam flrsp_regs_t REGS_RST = '{
        st: FLRSP_RUN, tmr: '0, tries: 3'h0,
        oc_lim: OC_THRESH_RST, uc_lim: UC_THRESH_RST,
        ot_lim: OT_THRESH_RST, ot_act: OT_ACTION_RST,
        ot_now: 1'b0, ot_flag: 1'b0, oc_flag: 1'b0, uc_flag: 1'b0,
        out_en: 1'b0, rdata: 16'h0000, rvalid: 1'b0, rerr: 1'b0
    };

    flrsp_regs_t q; // registered state
    flrsp_regs_t d; // next state
    logic [1:0] mode; // response mode field
    logic [2:0] retry; // retry setting field
    logic [2:0] units; // delay unit count field
    logic ot_det; // this measurement is over the limit
    logic oc_det; // current over its upper threshold
    logic uc_det; // current under its lower threshold
    logic wr_word; // word write accepted
    logic wr_byte; // byte write accepted
    logic tries_left; // another restart attempt is allowed
    logic [TMR_W-1:0] run_load; // continued-operation delay
    logic [TMR_W-1:0] retry_load; // spacing of attempts

    assign mode = q.ot_act[ACT_MODE_HI:ACT_MODE_LO];
    assign retry = q.ot_act[ACT_RETRY_HI:ACT_RETRY_LO];
    assign units = q.ot_act[ACT_DELAY_HI:ACT_DELAY_LO];
    // threshold compare
    // raw compare of the linear words; both share the same exponent
    assign ot_det = temp_valid && (temp_value > q.ot_lim);
    assign oc_det = iout_valid && (iout_value > q.oc_lim);
    assign uc_det = iout_valid && (iout_value < q.uc_lim);
    assign run_load = TMR_W'(32'(units) * 32'(RUN_UNIT));
    assign retry_load = TMR_W'(32'(units) * 32'(RETRY_UNIT));
    assign tries_left = (retry == RETRY_ENDLESS) || (q.tries < retry);
    assign wr_word = cmd_valid && cmd_write && cmd_word;
    assign wr_byte = cmd_valid && cmd_write && !cmd_word;

    // next-state logic for registers, flags and the response machine
    always_comb
    begin
        d = q;
        d.rvalid = cmd_valid;
        d.rerr = 1'b0;
        // register access, decoded by command code
        if (cmd_valid && (cmd_code == CMD_OC_THRESH))
        begin
            if (!cmd_word)
                d.rerr = 1'b1;
            else if (wr_word)
                d.oc_lim = cmd_wdata;
            d.rdata = q.oc_lim;
        end
        else if (cmd_valid && (cmd_code == CMD_UC_THRESH))
        begin
            if (!cmd_word)
                d.rerr = 1'b1;
            else if (wr_word)
                d.uc_lim = cmd_wdata;
            d.rdata = q.uc_lim;
        end
        else if (cmd_valid && (cmd_code == CMD_OT_THRESH))
        begin
            if (!cmd_word)
                d.rerr = 1'b1;
            else if (wr_word)
                d.ot_lim = cmd_wdata;
            d.rdata = q.ot_lim;
        end
        else if (cmd_valid && (cmd_code == CMD_OT_ACTION))
        begin
            if (cmd_word)
                d.rerr = 1'b1;
            else if (wr_byte)
                d.ot_act = cmd_wdata[7:0];
            d.rdata = {8'h00, q.ot_act};
        end
        else if (cmd_valid)
        begin
            // unknown code: refused, reads zero
            d.rerr = 1'b1;
            d.rdata = 16'h0000;
        end
        // latest temperature verdict, kept between measurements
        if (temp_valid)
            d.ot_now = ot_det;
        // sticky flags: a set in the clear cycle wins
        if (fault_clear)
        begin
            d.ot_flag = 1'b0;
            d.oc_flag = 1'b0;
            d.uc_flag = 1'b0;
        end
        if (ot_det)
            d.ot_flag = 1'b1;
        if (oc_det)
            d.oc_flag = 1'b1;
        if (uc_det)
            d.uc_flag = 1'b1;
        // timer counts down to zero and rests there
        if (q.tmr != '0)
            d.tmr = q.tmr - TMR_W'(1);
        case (q.st)
            FLRSP_RUN:
            begin
                // a new episode starts with a fresh attempt count
                if (ot_det && op_enable)
                begin
                    d.tries = 3'h0;
                    case (mode)
                        MODE_IGNORE:
                            d.st = FLRSP_RUN;
                        MODE_RUN_RETRY:
                        begin
                            d.st = FLRSP_DELAY;
                            d.tmr = run_load;
                        end
                        MODE_OFF_RETRY:
                        begin
                            d.st = (retry == RETRY_NONE) ? FLRSP_LATCH : FLRSP_OFFWAIT;
                            d.tmr = retry_load;
                        end
                        default:
                            d.st = FLRSP_HOLD;
                    endcase
                end
            end
            FLRSP_DELAY:
            begin
                if (q.tmr == '0)
                begin
                    if (!q.ot_now)
                        d.st = FLRSP_RUN;
                    else if (retry == RETRY_NONE)
                        d.st = FLRSP_LATCH;
                    else
                    begin
                        d.st = FLRSP_OFFWAIT;
                        d.tmr = retry_load;
                    end
                end
            end
            FLRSP_OFFWAIT:
            begin
                if (q.tmr == '0)
                begin
                    d.st = FLRSP_RESTART;
                    d.tmr = retry_load;
                    d.tries = q.tries + 3'h1;
                end
            end
            FLRSP_RESTART:
            begin
                // an attempt fails if the fault shows while it runs
                if (ot_det)
                begin
                    if (tries_left)
                        d.st = FLRSP_OFFWAIT; // timer runs on from the attempt start
                    else
                        d.st = FLRSP_LATCH;
                end
                else if (q.tmr == '0)
                    d.st = FLRSP_RUN;
            end
            FLRSP_LATCH:
            begin
                if (fault_clear)
                    d.st = FLRSP_RUN;
            end
            FLRSP_HOLD:
            begin
                if (!q.ot_now)
                    d.st = FLRSP_RUN;
            end
            default:
                d.st = FLRSP_RUN;
        endcase
        if (!op_enable)
            d.st = FLRSP_RUN;
        // output runs only in the operating states
        d.out_en = op_enable && ((d.st == FLRSP_RUN) || (d.st == FLRSP_DELAY)
                   || (d.st == FLRSP_RESTART));
    end
    // single state register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            q <= REGS_RST;
        else
            q <= d;
    end
    // outputs straight from the state register
    assign rsp_rdata = q.rdata;
    assign rsp_valid = q.rvalid;
    assign rsp_err = q.rerr;
    assign out_enable = q.out_en;
    assign ot_fault_flag = q.ot_flag;
    assign oc_fault_flag = q.oc_flag;
    assign uc_fault_flag = q.uc_flag;
    assign alert_output_line_n = !(q.ot_flag || q.oc_flag || q.uc_flag);
    // checks of register access and the fault response
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_oc_write_word: assert property (
        wr_word && (cmd_code == CMD_OC_THRESH) |=> q.oc_lim == $past(cmd_wdata))
        else $error("over-current threshold not stored");
    a_uc_write_word: assert property (
        wr_word && (cmd_code == CMD_UC_THRESH) |=> rsp_valid && q.uc_lim == $past(cmd_wdata))
        else $error("under-current threshold not stored");
    a_ot_readback: assert property (
        cmd_valid && !cmd_write && cmd_word && (cmd_code == CMD_OT_THRESH)
        |=> rsp_rdata == $past(q.ot_lim) && !rsp_err)
        else $error("temperature threshold readback wrong");
    a_byte_width_check: assert property (
        cmd_valid && cmd_word && (cmd_code == CMD_OT_ACTION) |=> rsp_err && $stable(q.ot_act))
        else $error("word transfer to action byte not refused");
    a_alert_on_fault: assert property (
        ot_det |=> !alert_output_line_n && ot_fault_flag)
        else $error("alert not raised on temperature fault");
    a_ignore_keeps_on: assert property (
        q.st == FLRSP_RUN && ot_det && mode == MODE_IGNORE && op_enable
        ##1 op_enable |=> out_enable)
        else $error("output dropped in ignore mode");
    a_delay_keeps_on: assert property (
        q.st == FLRSP_DELAY && op_enable && q.tmr != '0 |=> out_enable)
        else $error("output dropped during run-on delay");
    a_disable_at_once: assert property (
        q.st == FLRSP_RUN && ot_det && mode == MODE_OFF_RETRY |=> !out_enable)
        else $error("output not disabled at fault");
    a_hold_release: assert property (
        q.st == FLRSP_HOLD && !q.ot_now && op_enable |=> q.st == FLRSP_RUN && out_enable)
        else $error("hold not released when fault gone");
    a_latch_off: assert property (
        q.st == FLRSP_LATCH |-> !out_enable)
        else $error("output on while latched off");
    a_tries_bounded: assert property (
        retry != RETRY_ENDLESS && q.st == FLRSP_RESTART |-> q.tries <= retry)
        else $error("too many restart attempts");
    a_episode_count: assert property (
        q.st == FLRSP_RUN && ot_det && op_enable && mode != MODE_IGNORE |=> q.tries == 3'h0)
        else $error("attempt count not reset");
    c_retry_success: cover property (
        q.st == FLRSP_RESTART && q.tmr == '0 && !ot_det ##1 q.st == FLRSP_RUN);
    c_latched: cover property (q.st == FLRSP_RESTART ##1 q.st == FLRSP_LATCH);
    c_delay_recover: cover property (q.st == FLRSP_DELAY ##1 q.st == FLRSP_RUN);
    c_hold: cover property (q.st == FLRSP_HOLD ##1 q.st == FLRSP_RUN);
endmodule

// ===== rtl/flrsp_pkg.sv
package flrsp_pkg;
    // command codes of the four registers kept here
    localparam logic [7:0] CMD_OC_THRESH = 8'h46;
    localparam logic [7:0] CMD_UC_THRESH = 8'h4B;
    localparam logic [7:0] CMD_OT_THRESH = 8'h4F;
    localparam logic [7:0] CMD_OT_ACTION = 8'h50;
    // reset contents; thresholds start at their most tolerant value
    localparam logic [15:0] OC_THRESH_RST = 16'hFFFF;
    localparam logic [15:0] UC_THRESH_RST = 16'h0000;
    localparam logic [15:0] OT_THRESH_RST = 16'hFFFF;
    localparam logic [7:0] OT_ACTION_RST = 8'h00;
    // fields of the over-temperature action byte
    localparam int ACT_MODE_HI = 7;
    localparam int ACT_MODE_LO = 6;
    localparam int ACT_RETRY_HI = 5;
    localparam int ACT_RETRY_LO = 3;
    localparam int ACT_DELAY_HI = 2;
    localparam int ACT_DELAY_LO = 0;
    // response modes
    localparam logic [1:0] MODE_IGNORE = 2'h0;
    localparam logic [1:0] MODE_RUN_RETRY = 2'h1;
    localparam logic [1:0] MODE_OFF_RETRY = 2'h2;
    localparam logic [1:0] MODE_OFF_CLEAR = 2'h3;
    // retry codes with a special meaning
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;
    // delay units and the clock rate
    localparam int CLK_HZ = 40_000_000;
    localparam int RUN_UNIT_MS = 80;
    localparam int RETRY_UNIT_MS = 32;
    localparam int RUN_UNIT_CYC = (CLK_HZ / 1000) * RUN_UNIT_MS;
    localparam int RETRY_UNIT_CYC = (CLK_HZ / 1000) * RETRY_UNIT_MS;
    // timer must hold seven of the longer unit
    localparam int TMR_W = 25;
    // fault response states, one-hot
    typedef enum logic [5:0] {
        FLRSP_RUN = 6'h01,
        FLRSP_DELAY = 6'h02,
        FLRSP_OFFWAIT = 6'h04,
        FLRSP_RESTART = 6'h08,
        FLRSP_LATCH = 6'h10,
        FLRSP_HOLD = 6'h20
    } flrsp_state_t;
endpackage

// ===== verif/flrsp_host_model.sv
`timescale 1ns/1ps
// bus engine side: hands the block one decoded transfer at a time
module flrsp_host_model
    import flrsp_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // decoded transfer request
    output logic cmd_valid,
    output logic cmd_write,
    output logic cmd_word,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    // idle at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_word = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // one transfer; code and data are scrambled on release so stale values never pass
    // word for thresholds, byte for action
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        input logic bad);
    begin
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        // a bad request flips the transfer size on purpose
        cmd_word <= (code != CMD_OT_ACTION) ^ bad;
        cmd_code <= code;
        cmd_wdata <= data;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        cmd_wdata <= ~data;
    end
    endtask
endmodule

// ===== verif/test_fault_limit_response_logic.sv
`timescale 1ns/1ps
// drives the fault block, checks register answers and output reactions
module test_fault_limit_response_logic
    import flrsp_pkg::*;
    ;
    // short delay units keep the run brief
    localparam int RUN_U = 20;
    localparam int RETRY_U = 8;
    localparam logic [15:0] OVER = 16'h0200;
    localparam logic [15:0] UNDER = 16'h0050;
    logic ref_clk;
    logic arst_n;
    logic cmd_valid, cmd_write, cmd_word;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata;
    logic rsp_valid, rsp_err;
    logic temp_valid, iout_valid, op_enable, fault_clear;
    logic [15:0] temp_value, iout_value;
    logic out_enable, ot_fault_flag, oc_fault_flag, uc_fault_flag, alert_output_line_n;
    // expected answers: {data matters, err, data}
    logic [17:0] exp_q[$];
    logic [15:0] mirror[logic [7:0]];
    int n_errors = 0;
    int samples_checked = 0;
    int r, f, g;

    flrsp_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    flrsp_fault_limit #(.RUN_UNIT(RUN_U), .RETRY_UNIT(RETRY_U)) dut (.ref_clk(ref_clk),
        .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_rdata(rsp_rdata),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .temp_valid(temp_valid),
        .temp_value(temp_value), .iout_valid(iout_valid), .iout_value(iout_value),
        .op_enable(op_enable), .fault_clear(fault_clear), .out_enable(out_enable),
        .ot_fault_flag(ot_fault_flag), .oc_fault_flag(oc_fault_flag),
        .uc_fault_flag(uc_fault_flag), .alert_output_line_n(alert_output_line_n));

    // free-running clock, 25 ns
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic cmp(input logic [16:0] e, input logic [16:0] a);
    begin
        samples_checked++;
        if (a !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, a, e);
        end
    end
    endtask

    task automatic lvl(input logic a, input logic e);
    begin
        cmp({16'h0000, e}, {16'h0000, a});
    end
    endtask

    task automatic tick(input int n);
    begin
        repeat (n) @(posedge ref_clk);
    end
    endtask

    // note the answer, then issue the transfer
    task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] data,
                       input logic bad);
    begin
        if (!mirror.exists(code))
            exp_q.push_back({2'b11, 16'h0000});
        else if (bad)
            exp_q.push_back({2'b01, 16'h0000});
        else
        begin
            exp_q.push_back({2'b10, mirror[code]});
            if (wr)
                mirror[code] = (code == CMD_OT_ACTION) ? {8'h00, data[7:0]} : data;
        end
        host.xfer(wr, code, data, bad);
    end
    endtask

    // one measurement strobe, temperature or current
    task automatic meas(input logic cur, input logic [15:0] v);
    begin
        @(posedge ref_clk);
        temp_valid <= !cur;
        iout_valid <= cur;
        temp_value <= v;
        iout_value <= v;
        @(posedge ref_clk);
        temp_valid <= 1'b0;
        iout_valid <= 1'b0;
    end
    endtask

    // abort any sequence, clear flags, load the action, run again
    task automatic prep(input logic [7:0] act);
    begin
        @(posedge ref_clk);
        op_enable <= 1'b0;
        fault_clear <= 1'b1;
        @(posedge ref_clk);
        fault_clear <= 1'b0;
        acc(1'b1, CMD_OT_ACTION, {8'h00, act}, 1'b0);
        op_enable <= 1'b1;
        tick(3);
    end
    endtask

    // heat once, then fault every restart; count restarts, time the first two
    // gap is start to start of the first two attempts, in clock cycles
    task automatic episode(input logic [7:0] act, output int rises, output int first,
                           output int gap);
    begin
        realtime t_prev;
        prep(act);
        meas(1'b0, OVER);
        rises = 0;
        first = 0;
        gap = 0;
        t_prev = $realtime;
        for (int i = 0; i < 300; i++)
        begin
            @(negedge ref_clk);
            if (out_enable === 1'b1)
            begin
                if (rises == 0)
                    first = i;
                if (rises == 1)
                    gap = int'(($realtime - t_prev) / 25.0);
                t_prev = $realtime;
                rises++;
                meas(1'b0, OVER);
                tick(2);
            end
        end
    end
    endtask

    // answer watcher: oldest note against each response
    always @(posedge ref_clk)
    begin
        if (rsp_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp(17'h1FFFF, {rsp_err, rsp_rdata});
            else
                cmp(exp_q[0][16:0], {rsp_err, exp_q[0][17] ? rsp_rdata : exp_q[0][15:0]});
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end

    task automatic give_verdict();
    begin
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // main sequence
    initial
    begin
        arst_n = 1'b0;
        {temp_valid, iout_valid, op_enable, fault_clear} = 4'h0;
        temp_value = 16'h0000;
        iout_value = 16'h0000;
        mirror[CMD_OC_THRESH] = OC_THRESH_RST;
        mirror[CMD_UC_THRESH] = UC_THRESH_RST;
        mirror[CMD_OT_THRESH] = OT_THRESH_RST;
        mirror[CMD_OT_ACTION] = {8'h00, OT_ACTION_RST};
        void'($urandom(32'h7042));
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        // reset values, random fill, then working limits
        foreach (mirror[c]) acc(1'b0, c, 16'h0000, 1'b0);
        foreach (mirror[c]) acc(1'b1, c, 16'($urandom()), 1'b0);
        acc(1'b1, CMD_OC_THRESH, 16'h1000, 1'b0);
        acc(1'b1, CMD_UC_THRESH, 16'h0100, 1'b0);
        acc(1'b1, CMD_OT_THRESH, 16'h0100, 1'b0);
        // wrong sizes and a hole in the map are refused
        acc(1'b1, CMD_OC_THRESH, 16'h1234, 1'b1);
        acc(1'b0, CMD_OT_ACTION, 16'h0000, 1'b1);
        acc(1'b0, 8'h47, 16'h0000, 1'b0);
        foreach (mirror[c]) acc(1'b0, c, 16'h0000, 1'b0);
        // ignore mode: flag and alert only
        prep({MODE_IGNORE, 6'h00});
        meas(1'b0, OVER);
        tick(2);
        lvl(ot_fault_flag, 1'b1);
        lvl(alert_output_line_n, 1'b0);
        lvl(out_enable, 1'b1);
        meas(1'b1, 16'h2000);
        meas(1'b1, 16'h0010);
        tick(2);
        lvl(oc_fault_flag, 1'b1);
        lvl(uc_fault_flag, 1'b1);
        // run on for one unit of RUN_U cycles, then off as the fault stays
        prep({MODE_RUN_RETRY, RETRY_NONE, 3'h1});
        meas(1'b0, OVER);
        tick(RUN_U - 6);
        lvl(out_enable, 1'b1);
        tick(10);
        lvl(out_enable, 1'b0);
        // run on with one retry: off after the delay, then one attempt
        prep({MODE_RUN_RETRY, 3'h1, 3'h1});
        meas(1'b0, OVER);
        tick(RUN_U + 10);
        lvl(out_enable, 1'b0);
        tick(12);
        lvl(out_enable, 1'b1);
        // cool down inside the delay: the output never drops
        prep({MODE_RUN_RETRY, 3'h1, 3'h1});
        meas(1'b0, OVER);
        meas(1'b0, UNDER);
        tick(RUN_U + 4);
        lvl(out_enable, 1'b1);
        // off while hot, back on when cool
        prep({MODE_OFF_CLEAR, 6'h00});
        meas(1'b0, OVER);
        tick(2);
        lvl(out_enable, 1'b0);
        meas(1'b0, UNDER);
        tick(2);
        lvl(out_enable, 1'b1);
        // disable and retry, counted restarts per code
        for (int c = 0; c < 5; c++)
        begin
            episode({MODE_OFF_RETRY, 3'(c), 3'h2}, r, f, g);
            cmp(17'(c), 17'(r));
            if (c > 0)
                lvl(f >= 2 * RETRY_U - 3 && f <= 2 * RETRY_U + 3, 1'b1);
            if (c > 1)
                lvl(g >= 2 * RETRY_U && g <= 2 * RETRY_U + 2, 1'b1);
        end
        episode({MODE_OFF_RETRY, RETRY_ENDLESS, 3'h2}, r, f, g);
        lvl(r > 6, 1'b1);
        lvl(g >= 2 * RETRY_U && g <= 2 * RETRY_U + 2, 1'b1);
        tick(5);
        if (exp_q.size() != 0)
            n_errors++;
        give_verdict();
    end
endmodule
